//--- src/nand_host_pkg.sv
// Constants, opcodes and types shared by the NAND host controller
package nand_host_pkg;
  // Clock and pin timing
  localparam int CLK_MHZ = 125;
  localparam int T_WSTROBE_NS = 16;
  localparam int T_RSTROBE_NS = 48;
  localparam int T_HOLD_NS = 16;
  localparam int T_BUSY_START_NS = 100;
  localparam int WSTROBE_CYC = (T_WSTROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int RSTROBE_CYC = (T_RSTROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int BUSY_START_CYC = (T_BUSY_START_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 4;
  // Page geometry
  localparam logic [11:0] PAGE_BYTES = 12'h840;
  localparam int PAGE_BITS = 6;
  localparam logic [2:0] MAX_PARTIAL = 3'h4;
  // Flash command codes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_COL_JUMP = 8'h05;
  localparam logic [7:0] CMD_COL_JUMP_CONFIRM = 8'hE0;
  localparam logic [7:0] CMD_CACHE_NEXT = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;
  localparam logic [7:0] CMD_PROG_LOAD = 8'h80;
  localparam logic [7:0] CMD_DATA_JUMP = 8'h85;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  // Operations that software requests through the control register
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_COL_OUT = 4'h2;
  localparam logic [3:0] OP_CACHE_NEXT = 4'h3;
  localparam logic [3:0] OP_CACHE_LAST = 4'h4;
  localparam logic [3:0] OP_CACHE_RAND = 4'h5;
  localparam logic [3:0] OP_PROG_LOAD = 4'h6;
  localparam logic [3:0] OP_DATA_JUMP = 4'h7;
  localparam logic [3:0] OP_PROG_CONFIRM = 4'h8;
  localparam logic [3:0] OP_STATUS = 4'h9;
  localparam logic [3:0] OP_RESUME = 4'hA;
  localparam logic [3:0] OP_RD_BYTE = 4'hB;
  localparam logic [3:0] OP_WR_BYTE = 4'hC;
  // Register offsets and fields
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COL = 8'h04;
  localparam logic [7:0] OFF_ROW = 8'h08;
  localparam logic [7:0] OFF_CFG = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam int CTRL_BYTE_LSB = 8;
  localparam int CFG_WP_RELEASE = 0;
  localparam int CFG_PROTECT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam int STAT_REFUSED = 2;
  localparam int PROGRAM_FAIL_BIT = 0;
  localparam int ARRAY_IDLE_BIT = 5;
  localparam int CACHE_READY_BIT = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SETUP = 3'h1,
    S_STROBE = 3'h3,
    S_HOLD = 3'h2,
    S_WAIT = 3'h6
  } seq_state_type;

  typedef enum logic [2:0] {
    K_END = 3'h0,
    K_CMD = 3'h1,
    K_ADDR = 3'h2,
    K_WDAT = 3'h3,
    K_RDAT = 3'h4,
    K_WAIT = 3'h5
  } step_kind_type;

  typedef struct packed {
    step_kind_type kind;
    logic [7:0] val;
  } step_type;
endpackage : nand_host_pkg

//--- src/nand_host.sv
// NAND flash host controller: AXI4-Lite registers to flash strobe sequences
//
// Contract
// (R1) Ready pin low means busy; wait high
// (R2) Protect pin high at power-on protects array
// (R3) Protect pin low disables block protection
// (R4) Page holds 2048 main plus 64 spare
// (R5) Full address is four address cycles
// (R6) Column bytes first, upper nibble low, rows
// (R7) Read: 00h, address, 30h, wait ready
// (R8) Device column advances each read strobe
// (R9) Short read cycles need extended data capture
// (R10) Column jump: 05h, two columns, E0h
// (R11) Chip select ignored during busy latency
// (R12) Cache next: 31h, page from column zero
// (R13) Sequential cache read crosses block boundaries
// (R14) Status bits 6 and 5 show cache, array
// (R15) After status polling send 00h to resume
// (R16) Last cache page uses 3Fh instead
// (R17) Random cache: 00h, address, 31h, column ignored
// (R18) Program: 80h, address, data, 10h
// (R19) 85h with new column redirects data loading
// (R20) Program pages of block in ascending order
// (R21) At most four partial programs per page
// (R22) Program result in status bit 0
// (R23) During program only status, reset accepted
//
// Implementation choices: the AXI4-Lite register port and the address map.
module nand_host
  import nand_host_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic cle,
  output logic ale,
  output logic ce_n,
  output logic we_n,
  output logic read_strobe_n,
  output logic wp_n,
  output logic powerup_protect_pin,
  output logic [7:0] io_out,
  output logic io_oe_n,
  input wire logic [7:0] io_in,
  input wire logic rb_in
);
  localparam logic [CNT_W-1:0] W_LAST = CNT_W'(WSTROBE_CYC - 1);
  localparam logic [CNT_W-1:0] R_LAST = CNT_W'(RSTROBE_CYC - 1);
  localparam logic [CNT_W-1:0] H_LAST = CNT_W'(HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] B_LAST = CNT_W'(BUSY_START_CYC - 1);

  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic wr_commit;
  seq_state_type state_r, state_nxt;
  logic [3:0] op_r, op_nxt, idx_r, idx_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic cle_r, cle_nxt, ale_r, ale_nxt, ce_n_r, ce_n_nxt, we_n_r, we_n_nxt;
  logic re_n_r, re_n_nxt, oe_n_r, oe_n_nxt, fail_r, fail_nxt, refused_r, refused_nxt;
  logic [7:0] io_out_r, io_out_nxt, rd_byte_r, rd_byte_nxt, wbyte_r, wbyte_nxt;
  logic [11:0] col_r, col_nxt;
  logic [15:0] row_r, row_nxt, last_row_r, last_row_nxt;
  logic [1:0] cfg_r, cfg_nxt;
  logic [2:0] prog_cnt_r, prog_cnt_nxt;
  logic prog_seen_r, prog_seen_nxt;
  logic rb_s1, rb_s2;
  logic [7:0] io_s1, io_s2;
  step_type cur_step;

  function automatic logic known_off(input logic [7:0] a);
    return a == OFF_CTRL || a == OFF_COL || a == OFF_ROW || a == OFF_CFG || a == OFF_STATUS;
  endfunction : known_off

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  function automatic step_type mk(input step_kind_type k, input logic [7:0] v);
    step_type s;
    s.kind = k;
    s.val = v;
    return s;
  endfunction : mk

  // Step list for each operation; an address step carries the byte index
  function automatic step_type step_of(input logic [3:0] op, input logic [3:0] idx);
    step_type s;
    s = mk(K_END, 8'h00);
    case (op)
      // (R5) read page with four address cycles
      // (R7) read setup, confirm, then wait ready
      OP_READ, OP_CACHE_RAND: begin
        if (idx == 4'h0) s = mk(K_CMD, CMD_READ_SETUP);
        else if (idx < 4'h5) s = mk(K_ADDR, 8'(idx - 4'h1));
        // (R17) random cache page closes with cache-next
        else if (idx == 4'h5) s = mk(K_CMD, (op == OP_READ) ? CMD_READ_CONFIRM : CMD_CACHE_NEXT);
        else if (idx == 4'h6) s = mk(K_WAIT, 8'h00);
      end
      // (R10) column jump carries only two column cycles
      OP_COL_OUT: begin
        if (idx == 4'h0) s = mk(K_CMD, CMD_COL_JUMP);
        else if (idx < 4'h3) s = mk(K_ADDR, 8'(idx - 4'h1));
        else if (idx == 4'h3) s = mk(K_CMD, CMD_COL_JUMP_CONFIRM);
      end
      // (R12) next cache page needs no address
      // (R16) last page swaps in the cache-last code
      OP_CACHE_NEXT, OP_CACHE_LAST: begin
        if (idx == 4'h0) s = mk(K_CMD, (op == OP_CACHE_NEXT) ? CMD_CACHE_NEXT : CMD_CACHE_LAST);
        else if (idx == 4'h1) s = mk(K_WAIT, 8'h00);
      end
      // (R18) program load opens with address cycles
      OP_PROG_LOAD: begin
        if (idx == 4'h0) s = mk(K_CMD, CMD_PROG_LOAD);
        else if (idx < 4'h5) s = mk(K_ADDR, 8'(idx - 4'h1));
      end
      // (R19) random data input redirects the load column
      OP_DATA_JUMP: begin
        if (idx == 4'h0) s = mk(K_CMD, CMD_DATA_JUMP);
        else if (idx < 4'h3) s = mk(K_ADDR, 8'(idx - 4'h1));
      end
      // (R23) only status follows confirm, issued once the wait sees ready
      OP_PROG_CONFIRM: begin
        if (idx == 4'h0) s = mk(K_CMD, CMD_PROG_CONFIRM);
        else if (idx == 4'h1) s = mk(K_WAIT, 8'h00);
        else if (idx == 4'h2) s = mk(K_CMD, CMD_STATUS);
        else if (idx == 4'h3) s = mk(K_RDAT, 8'h00);
      end
      OP_STATUS: begin
        if (idx == 4'h0) s = mk(K_CMD, CMD_STATUS);
        else if (idx == 4'h1) s = mk(K_RDAT, 8'h00);
      end
      // (R15) read setup alone leaves status output
      OP_RESUME: begin
        if (idx == 4'h0) s = mk(K_CMD, CMD_READ_SETUP);
      end
      OP_RD_BYTE: begin
        if (idx == 4'h0) s = mk(K_RDAT, 8'h00);
      end
      OP_WR_BYTE: begin
        if (idx == 4'h0) s = mk(K_WDAT, 8'h00);
      end
      default: s = mk(K_END, 8'h00);
    endcase
    return s;
  endfunction : step_of

  // (R6) byte order of the address cycles
  function automatic logic [7:0] addr_byte(input logic [1:0] sel, input logic [11:0] col,
                                           input logic [15:0] row);
    case (sel)
      2'h0: return col[7:0];
      2'h1: return {4'h0, col[11:8]};
      2'h2: return row[7:0];
      default: return row[15:8];
    endcase
  endfunction : addr_byte

  assign awready = !aw_got_r && !bvalid_r;
  assign wready = !w_got_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign wr_commit = aw_got_r && w_got_r;
  assign cur_step = step_of(op_r, idx_r);

  always_comb begin
    aw_got_nxt = aw_got_r;
    aw_addr_nxt = aw_addr_r;
    w_got_nxt = w_got_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (awvalid && awready) begin
      aw_got_nxt = 1'b1;
      aw_addr_nxt = awaddr;
    end
    if (wvalid && wready) begin
      w_got_nxt = 1'b1;
      w_data_nxt = wdata;
      w_strb_nxt = wstrb;
    end
    if (wr_commit) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = known_off(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = known_off(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        OFF_CTRL: rdata_nxt = {16'h0000, wbyte_r, 4'h0, op_r};
        OFF_COL: rdata_nxt = {20'h00000, col_r};
        OFF_ROW: rdata_nxt = {16'h0000, row_r};
        OFF_CFG: rdata_nxt = {30'h00000000, cfg_r};
        // (R14) cache-ready and array-idle copied from the last byte read
        OFF_STATUS: rdata_nxt = {13'h0000, prog_cnt_r, rd_byte_r, 2'h0,
                                 rd_byte_r[ARRAY_IDLE_BIT], rd_byte_r[CACHE_READY_BIT],
                                 fail_r, refused_r, rb_s2, state_r != S_IDLE};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      aw_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_got_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else begin
      aw_got_r <= aw_got_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_got_r <= w_got_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  always_comb begin
    logic [31:0] m;
    logic [3:0] req;
    logic ok, start, set_refused, clr_refused;
    step_type ns;
    m = 32'h00000000;
    req = w_data_r[3:0];
    ok = 1'b0;
    start = 1'b0;
    set_refused = 1'b0;
    clr_refused = 1'b0;
    ns = mk(K_END, 8'h00);
    state_nxt = state_r;
    {op_nxt, idx_nxt, cnt_nxt} = {op_r, idx_r, cnt_r};
    {cle_nxt, ale_nxt, ce_n_nxt, we_n_nxt, re_n_nxt, oe_n_nxt} =
      {cle_r, ale_r, ce_n_r, we_n_r, re_n_r, oe_n_r};
    {io_out_nxt, rd_byte_nxt, wbyte_nxt, fail_nxt} = {io_out_r, rd_byte_r, wbyte_r, fail_r};
    {col_nxt, row_nxt, cfg_nxt} = {col_r, row_r, cfg_r};
    {last_row_nxt, prog_cnt_nxt, prog_seen_nxt} = {last_row_r, prog_cnt_r, prog_seen_r};
    if (wr_commit) begin
      m = merge(32'h00000000, w_data_r, w_strb_r);
      case (aw_addr_r)
        OFF_COL: col_nxt = 12'(merge({20'h00000, col_r}, w_data_r, w_strb_r));
        OFF_ROW: row_nxt = 16'(merge({16'h0000, row_r}, w_data_r, w_strb_r));
        OFF_CFG: cfg_nxt = 2'(merge({30'h00000000, cfg_r}, w_data_r, w_strb_r));
        OFF_STATUS: clr_refused = m[STAT_REFUSED];
        OFF_CTRL: begin
          ok = req >= OP_READ && req <= OP_WR_BYTE;
          // (R4) a column beyond the spare area is refused
          if ((req == OP_READ || req == OP_COL_OUT || req == OP_PROG_LOAD ||
               req == OP_DATA_JUMP) && col_r >= PAGE_BYTES) ok = 1'b0;
          // (R20) a lower page of the same block is refused
          if (req == OP_PROG_LOAD && prog_seen_r &&
              row_r[15:PAGE_BITS] == last_row_r[15:PAGE_BITS] &&
              row_r[PAGE_BITS-1:0] < last_row_r[PAGE_BITS-1:0]) ok = 1'b0;
          // (R21) a fifth partial program of one page is refused
          if (req == OP_PROG_LOAD && prog_seen_r && row_r == last_row_r &&
              prog_cnt_r == MAX_PARTIAL) ok = 1'b0;
          // (R23) nothing new starts while a sequence or program runs
          if (state_r != S_IDLE || !w_strb_r[0]) ok = 1'b0;
          start = ok;
          set_refused = !ok;
        end
        default: ;
      endcase
    end
    // Set wins over a clear landing in the same cycle
    refused_nxt = set_refused || (refused_r && !clr_refused);
    case (state_r)
      S_IDLE: begin
        if (start) begin
          op_nxt = req;
          idx_nxt = 4'h0;
          wbyte_nxt = w_data_r[CTRL_BYTE_LSB +: 8];
          state_nxt = S_SETUP;
          if (req == OP_PROG_LOAD) begin
            prog_cnt_nxt = (prog_seen_r && row_r == last_row_r) ? prog_cnt_r + 3'h1 : 3'h1;
            last_row_nxt = row_r;
            prog_seen_nxt = 1'b1;
          end
        end
      end
      S_SETUP: begin
        case (cur_step.kind)
          K_END: state_nxt = S_IDLE;
          K_WAIT: begin
            state_nxt = S_WAIT;
            cnt_nxt = B_LAST;
          end
          K_RDAT: begin
            state_nxt = S_STROBE;
            re_n_nxt = 1'b0;
            cnt_nxt = R_LAST;
          end
          default: begin
            state_nxt = S_STROBE;
            we_n_nxt = 1'b0;
            cnt_nxt = W_LAST;
          end
        endcase
      end
      S_STROBE: begin
        if (cnt_r == '0) begin
          we_n_nxt = 1'b1;
          re_n_nxt = 1'b1;
          state_nxt = S_HOLD;
          cnt_nxt = H_LAST;
          // (R9) slow cycles let the byte be taken before the strobe rises
          if (!re_n_r) begin
            rd_byte_nxt = io_s2;
            // (R22) status byte after program holds the fail flag
            if (op_r == OP_PROG_CONFIRM) fail_nxt = io_s2[PROGRAM_FAIL_BIT];
          end
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      S_HOLD: begin
        if (cnt_r == '0) begin
          idx_nxt = idx_r + 4'h1;
          state_nxt = S_SETUP;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      S_WAIT: begin
        // (R1) busy ends once the synchronised ready pin is high
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else if (rb_s2) begin
          idx_nxt = idx_r + 4'h1;
          state_nxt = S_SETUP;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
    // Pins for the coming step settle one cycle before its strobe
    if (state_nxt == S_SETUP && state_r != S_SETUP) begin
      ns = step_of(op_nxt, idx_nxt);
      cle_nxt = ns.kind == K_CMD;
      ale_nxt = ns.kind == K_ADDR;
      oe_n_nxt = !(ns.kind == K_CMD || ns.kind == K_ADDR || ns.kind == K_WDAT);
      // (R11) select released while the flash is busy
      ce_n_nxt = ns.kind == K_WAIT || ns.kind == K_END;
      if (ns.kind == K_CMD) io_out_nxt = ns.val;
      else if (ns.kind == K_ADDR) io_out_nxt = addr_byte(ns.val[1:0], col_r, row_r);
      else if (ns.kind == K_WDAT) io_out_nxt = wbyte_nxt;
    end else if (state_nxt == S_IDLE) begin
      {cle_nxt, ale_nxt, ce_n_nxt, oe_n_nxt} = 4'h3;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= S_IDLE;
      {op_r, idx_r, cnt_r} <= '0;
      {cle_r, ale_r, ce_n_r, we_n_r, re_n_r, oe_n_r} <= 6'h0F;
      {io_out_r, rd_byte_r, wbyte_r} <= '0;
      {fail_r, refused_r, prog_seen_r} <= 3'h0;
      {col_r, row_r, last_row_r, prog_cnt_r} <= '0;
      cfg_r <= CFG_RESET;
    end else begin
      state_r <= state_nxt;
      {op_r, idx_r, cnt_r} <= {op_nxt, idx_nxt, cnt_nxt};
      {cle_r, ale_r, ce_n_r, we_n_r, re_n_r, oe_n_r} <=
        {cle_nxt, ale_nxt, ce_n_nxt, we_n_nxt, re_n_nxt, oe_n_nxt};
      {io_out_r, rd_byte_r, wbyte_r} <= {io_out_nxt, rd_byte_nxt, wbyte_nxt};
      {fail_r, refused_r, prog_seen_r} <= {fail_nxt, refused_nxt, prog_seen_nxt};
      {col_r, row_r, last_row_r, prog_cnt_r} <= {col_nxt, row_nxt, last_row_nxt, prog_cnt_nxt};
      cfg_r <= cfg_nxt;
    end
  end

  // Pin inputs cross into the clock domain through two flops
  always_ff @(posedge clock) begin
    rb_s1 <= rb_in;
    rb_s2 <= rb_s1;
    io_s1 <= io_in;
    io_s2 <= io_s1;
  end

  assign {cle, ale, ce_n, we_n, read_strobe_n, io_oe_n, io_out} =
    {cle_r, ale_r, ce_n_r, we_n_r, re_n_r, oe_n_r, io_out_r};
  assign wp_n = cfg_r[CFG_WP_RELEASE];
  // (R3) low out of reset keeps block protection off
  // (R2) software drives it high to protect before power-on
  assign powerup_protect_pin = cfg_r[CFG_PROTECT];

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_we_pulse;
    !we_n [*2] ##1 we_n;
  endsequence

  chk_latch_exclusive: assert property (!(cle && ale)) else $error("cle and ale both high"); // R5
  chk_write_strobe: assert property ($fell(we_n) |-> s_we_pulse) else $error("we_n pulse width"); // R5
  chk_col_nibble: assert property (ale && !we_n && cur_step.val == 8'h01 |-> io_out[7:4] == 4'h0)
    else $error("column high nibble not low"); // R6
  chk_ready_resume: assert property (state_r == S_WAIT && cnt_r == '0 && rb_s2 |=> state_r == S_SETUP)
    else $error("ready not followed"); // R7
  chk_busy_hold: assert property (state_r == S_WAIT && !rb_s2 && cnt_r == '0 |=> state_r == S_WAIT)
    else $error("left wait while busy"); // R1
  chk_bus_release: assert property (!read_strobe_n |-> io_oe_n) else $error("bus driven in read"); // R9
  chk_read_capture: assert property ($rose(read_strobe_n) |-> rd_byte_r == $past(io_s2, 1))
    else $error("read byte not captured"); // R9
  chk_select_free: assert property (state_r == S_WAIT |-> ce_n) else $error("select held in wait"); // R11
  chk_cache_code: assert property (cle && !we_n && op_r == OP_CACHE_NEXT |-> io_out == CMD_CACHE_NEXT)
    else $error("wrong cache-next code"); // R12
  chk_busy_refuse: assert property (wr_commit && aw_addr_r == OFF_CTRL && state_r != S_IDLE
    |=> refused_r && op_r == $past(op_r)) else $error("start not refused"); // R23
  chk_fail_flag: assert property ($rose(read_strobe_n) && op_r == OP_PROG_CONFIRM
    |-> fail_r == $past(io_s2[PROGRAM_FAIL_BIT], 1)) else $error("fail flag wrong"); // R22
endmodule : nand_host

//--- test/flash_model.sv
// Behavioural flash device answering the controller's strobes
module flash_model #(
  parameter int BUSY_NS = 1000,
  parameter int CBUSY_NS = 200
) (
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic read_strobe_n,
  input wire logic wp_n,
  input wire logic powerup_protect_pin,
  input wire logic [7:0] io,
  input wire logic fail_next,
  output logic rb,
  output logic [7:0] dq,
  output logic drv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int];
  logic [7:0] pl [int];
  logic [7:0] cmd = 8'h00;
  logic [11:0] col = 12'h000;
  logic [15:0] row = 16'h0000;
  logic [15:0] page = 16'h0000;
  int na = 0;
  logic sm = 1'b0, rnd = 1'b0, prog = 1'b0, fail = 1'b0, idle = 1'b1, lock = 1'b0;
  initial rb = 1'b1;
  initial dq = 8'h00;
  // protection only when the pin was high at power-on
  initial #1 lock = (powerup_protect_pin === 1'b1);
  // columns reach into the spare area; unwritten bytes follow a pattern
  function automatic logic [7:0] pb(input logic [15:0] p, input logic [11:0] c);
    int k = {p, 4'h0, c};
    return mem.exists(k) ? mem[k] : p[7:0] ^ c[7:0] ^ 8'hA5;
  endfunction : pb
  // busy runs on its own, whatever chip select does
  task automatic busy(input int t);
    rb = 1'b0;
    rb <= #(t) 1'b1;
  endtask : busy
  task automatic docmd(input logic [7:0] c);
    cmd = c;
    na = 0;
    sm = (c == 8'h70);
    case (c)
      8'h30: begin
        page = row;
        rnd = 1'b0;
        busy(BUSY_NS);
      end
      // next page from column zero, random if addressed
      8'h31, 8'h3F: begin
        page = rnd ? row : page + 16'h0001;
        col = 12'h000;
        rnd = 1'b0;
        idle = 1'b0;
        idle <= #(3 * BUSY_NS) 1'b1;
        busy(CBUSY_NS);
      end
      8'h80: pl.delete();
      // confirm stores the loaded bytes unless the program fails, and records the result
      8'h10: begin
        fail = fail_next || !wp_n || lock;
        if (!fail) foreach (pl[k]) mem[{row, 4'h0, 12'(k)}] = pl[k];
        prog = 1'b1;
        prog <= #(BUSY_NS) 1'b0;
        busy(BUSY_NS);
      end
      default: ;
    endcase
  endtask : docmd
  // latch on the rising write strobe
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      // a running program lets only status and reset through
      if (!prog || io == 8'h70 || io == 8'hFF) docmd(io);
    end else if (!ce_n && ale && !prog) begin
      case (na)
        0: col[7:0] = io;
        1: col[11:8] = io[3:0];
        2: row[7:0] = io;
        default: row[15:8] = io;
      endcase
      if (na == 2 && cmd == 8'h00) rnd = 1'b1;
      na++;
    end else if (!ce_n && !prog) begin
      pl[int'(col)] = io;
      col++;
    end
  end
  // each falling read strobe shows a byte; status shows ready and idle
  always @(negedge read_strobe_n) begin
    if (!ce_n) begin
      dq = sm ? {wp_n, rb, idle, 4'h0, fail} : pb(page, col);
      if (!sm) col++;
    end
  end
  assign drv = !ce_n && !read_strobe_n;
endmodule : flash_model

//--- test/nand_host_bench.sv
// Self-checking bench for the flash host controller
module nand_host_bench
  import nand_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, srst = 1'b1, fail_next = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, io_out, io_in, dq;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, cle, ale, ce_n, we_n, read_strobe_n;
  logic wp_n, powerup_protect_pin, io_oe_n, rb, drv;
  logic [1:0] bresp, rresp, resp;
  int n_errors = 0, n_checks = 0;
  nand_host nand_host_inst (.clock, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .cle, .ale, .ce_n, .we_n, .read_strobe_n, .wp_n, .powerup_protect_pin,
    .io_out, .io_oe_n, .io_in, .rb_in(rb));
  flash_model flash_model_inst (.ce_n, .cle, .ale, .we_n, .read_strobe_n, .wp_n,
    .powerup_protect_pin, .io(io_out), .fail_next, .rb, .dq, .drv);
  // Released data lines show the inverse so a stale capture cannot pass
  assign io_in = !io_oe_n ? io_out : drv ? dq : ~dq;
  initial forever #4 clock = ~clock;
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  task automatic hang();
    n_errors++;
    complete_run();
  endtask : hang
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    resp = bresp;
    bready <= 1'b0;
    if (n >= 200) hang();
  endtask : axw
  task automatic axr(input logic [7:0] a);
    int n = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n >= 200) hang();
  endtask : axr
  // Start an operation, then poll until the busy flag clears
  task automatic op(input logic [3:0] c, input logic [7:0] b = 8'h00);
    int n = 0;
    axw(OFF_CTRL, {16'h0, b, 4'h0, c});
    do begin
      axr(OFF_STATUS);
      n++;
    end while (rd[0] !== 1'b0 && n < 500);
    if (n >= 500) hang();
  endtask : op
  task automatic rbyte(input string nm, input logic [7:0] e);
    op(OP_RD_BYTE);
    chk(nm, rd & 32'hFF00, {16'h0, e, 8'h00});
  endtask : rbyte
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    axr(OFF_CFG);
    chk("cfg", rd, 32'h0);
    axr(8'h14);
    chk("rd_unmapped", 32'(resp), 32'(RESP_SLVERR));
    axw(8'h14, 32'h1);
    chk("wr_unmapped", 32'(resp), 32'(RESP_SLVERR));
    axw(OFF_CFG, 32'h3);
    chk("pins", {30'h0, powerup_protect_pin, wp_n}, 32'h3);
    axw(OFF_CFG, 32'h1);
    axw(OFF_COL, 32'h2);
    axw(OFF_ROW, 32'h101);
    op(OP_PROG_LOAD);
    op(OP_WR_BYTE, 8'h11);
    op(OP_WR_BYTE, 8'h22);
    axw(OFF_COL, 32'h83F);
    op(OP_DATA_JUMP);
    op(OP_WR_BYTE, 8'h33);
    op(OP_PROG_CONFIRM);
    chk("prog_ok", rd & 32'h7000C, 32'h10000);
    axw(OFF_COL, 32'h2);
    op(OP_READ);
    rbyte("byte0", 8'h11);
    rbyte("byte1", 8'h22);
    axw(OFF_COL, 32'h83F);
    op(OP_COL_OUT);
    rbyte("spare", 8'h33);
    axw(OFF_COL, 32'h840);
    op(OP_READ);
    chk("col_limit", rd & 32'h4, 32'h4);
    axw(OFF_STATUS, 32'h4);
    axw(OFF_COL, 32'h0);
    axw(OFF_ROW, 32'h100);
    op(OP_PROG_LOAD);
    chk("page_order", rd & 32'h4, 32'h4);
    axw(OFF_ROW, 32'h103);
    for (int i = 0; i < 5; i++) begin
      axw(OFF_STATUS, 32'h4);
      op(OP_PROG_LOAD);
      chk("partial", rd & 32'h4, (i == 4) ? 32'h4 : 32'h0);
      if (i < 4) op(OP_PROG_CONFIRM);
    end
    axw(OFF_STATUS, 32'h4);
    axw(OFF_ROW, 32'h104);
    fail_next <= 1'b1;
    op(OP_PROG_LOAD);
    op(OP_PROG_CONFIRM);
    chk("prog_fail", rd & 32'hC, 32'h8);
    fail_next <= 1'b0;
    axw(OFF_ROW, 32'h3F);
    op(OP_READ);
    op(OP_CACHE_NEXT);
    rbyte("cache_next", 8'hE5);
    op(OP_STATUS);
    chk("cache_stat", rd & 32'h30, 32'h10);
    op(OP_RESUME);
    rbyte("resume", 8'hE4);
    op(OP_CACHE_LAST);
    rbyte("cache_last", 8'hE4);
    axw(OFF_COL, 32'h123);
    axw(OFF_ROW, 32'h207);
    op(OP_CACHE_RAND);
    rbyte("cache_rand", 8'hA2);
    axw(OFF_CTRL, 32'h9);
    op(OP_STATUS);
    chk("busy_refuse", rd & 32'h4, 32'h4);
    complete_run();
  end
endmodule : nand_host_bench
